// *** include/dswdt_pkg.sv ***
// Package for the dual stage watchdog: register map, fields, action codes
package dswdt_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00; // Stage actions and enable
   localparam logic [7:0] REG_STAGE1  = 8'h04; // First stage count
   localparam logic [7:0] REG_STAGE2  = 8'h08; // Second stage count
   localparam logic [7:0] REG_TRIGGER = 8'h0c; // Service write
   localparam logic [7:0] REG_STATUS  = 8'h10; // Sticky events, read clears
   localparam logic [7:0] REG_MASK    = 8'h14; // Interrupt mask
   localparam logic [7:0] REG_STATE   = 8'h18; // Live sequencer state
   // Control field positions
   localparam int CTRL_ACT1_LSB = 0;  // Stage one action code
   localparam int CTRL_ACT2_LSB = 4;  // Stage two action code
   localparam int CTRL_EN_BIT   = 8;  // Watchdog enable
   // Status bit positions
   localparam int ST_EXP1_BIT   = 0;  // Stage one expired
   localparam int ST_EXP2_BIT   = 1;  // Stage two expired
   localparam int ST_TOUT_BIT   = 2;  // Timeout output asserted
   localparam int ST_RST_BIT    = 3;  // Module reset issued
   localparam int STATUS_W      = 4;  // Status width
   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000; // All stages off
   localparam logic [31:0] COUNT_RST = 32'h0000_ffff; // Default stage count
   localparam logic [3:0]  MASK_RST  = 4'h0;          // All masked
   // Action codes
   localparam logic [3:0] ACT_OFF       = 4'h0; // Skip stage
   localparam logic [3:0] ACT_RESET     = 4'h1; // Module reset
   localparam logic [3:0] ACT_DELAY     = 4'h5; // Delay, first stage only
   localparam logic [3:0] ACT_TOUT      = 4'h8; // Timeout output only
   localparam logic [3:0] ACT_RST_TOUT  = 4'h9; // Output and reset
   localparam logic [3:0] ACT_DLY_TOUT  = 4'hd; // Delay with output
   // Module reset pulse length
   localparam logic [3:0] RST_PULSE_CYC = 4'h8;
   // Decoded action of one stage
   typedef struct packed {
      logic enabled;  // Stage counts
      logic do_reset; // Expiry resets module
      logic do_tout;  // Expiry asserts timeout output
   } dswdt_act_t;
endpackage : dswdt_pkg

// *** design/dswdt_top.sv ***
// Dual stage watchdog with AHB-Lite register slave
// Operation
// - Two independent stages run in sequence
// - Trigger write services; missed service acts
// - Code 0000b stage skipped, no action
// - Code 0001b expiry resets the module
// - Code 0101b delay, first stage only
// - 1000b output, 1001b both, 1101b delay+output
// - Output asserts when trigger interval missed
// - Output tied to stage by configuration
// - Output holds until reset, then clears
`timescale 1ns/1ps
module dswdt_top #(
   parameter int CNT_W = 32 // Stage counter width
) (
   input  wire logic        core_clk_i,            // Module clock
   input  wire logic        reset_n_i,             // Async reset, active low
   input  wire logic        hsel_i,                // AHB select
   input  wire logic [31:0] haddr_i,               // AHB address
   input  wire logic [1:0]  htrans_i,              // AHB transfer type
   input  wire logic        hwrite_i,              // AHB write
   input  wire logic [2:0]  hsize_i,               // AHB size
   input  wire logic [31:0] hwdata_i,              // AHB write data
   input  wire logic        hready_i,              // AHB bus ready
   output logic      [31:0] hrdata_o,              // AHB read data
   output logic             hreadyout_o,           // AHB slave ready
   output logic             hresp_o,               // AHB response
   output logic             watchdog_timeout_out_o,// Timeout pin
   output logic             module_reset_o,        // Module reset request
   output logic             irq_o                  // Level interrupt
);
   // Sequencer states
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001, // Disabled
      S_ST1   = 4'b0010, // Counting stage one
      S_ST2   = 4'b0100, // Counting stage two
      S_DONE  = 4'b1000  // Final action taken
   } dswdt_state_t;

   // Decode one action code; delay only allowed in stage one
   function automatic dswdt_pkg::dswdt_act_t decode_act(input logic [3:0] code,
                                                       input logic first);
      dswdt_pkg::dswdt_act_t a;
      a = '0;
      case (code)
         dswdt_pkg::ACT_OFF:      a = '0;
         dswdt_pkg::ACT_RESET:    a = '{1'b1, 1'b1, 1'b0};
         dswdt_pkg::ACT_DELAY:    a = '{first, 1'b0, 1'b0};
         dswdt_pkg::ACT_TOUT:     a = '{1'b1, 1'b0, 1'b1};
         dswdt_pkg::ACT_RST_TOUT: a = '{1'b1, 1'b1, 1'b1};
         dswdt_pkg::ACT_DLY_TOUT: a = '{first, 1'b0, first};
         default:                 a = '0;                    // Unknown codes off
      endcase
      return a;
   endfunction : decode_act

   logic [31:0]          ctrl;          // Control register
   logic [CNT_W-1:0]     count1;        // Stage one reload
   logic [CNT_W-1:0]     count2;        // Stage two reload
   logic [dswdt_pkg::STATUS_W-1:0] status; // Sticky events
   logic [dswdt_pkg::STATUS_W-1:0] mask;   // Interrupt mask
   logic [CNT_W-1:0]     cnt;           // Running counter
   dswdt_state_t         state;         // Sequencer state
   logic [3:0]           rst_cnt;       // Reset pulse counter
   logic                 ap_valid;      // Address phase captured
   logic                 ap_write;      // Captured direction
   logic [7:0]           ap_addr;       // Captured offset
   logic                 wr_en;         // Data phase write
   logic                 rd_en;         // Data phase read
   logic                 trigger;       // Service strobe
   logic                 cfg_write;     // Reconfiguration strobe
   logic                 expire;        // Current stage ran out
   logic [dswdt_pkg::STATUS_W-1:0] events; // Event pulses
   dswdt_pkg::dswdt_act_t act1;         // Stage one decode
   dswdt_pkg::dswdt_act_t act2;         // Stage two decode
   logic                 en;            // Watchdog enable

   assign act1 = decode_act(ctrl[dswdt_pkg::CTRL_ACT1_LSB +: 4], 1'b1);
   assign act2 = decode_act(ctrl[dswdt_pkg::CTRL_ACT2_LSB +: 4], 1'b0);
   assign en   = ctrl[dswdt_pkg::CTRL_EN_BIT];

   // Capture AHB address phase
   // Only the low byte of the address is decoded
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr  <= 8'h00;
      end else if (hready_i) begin
         ap_valid <= hsel_i && htrans_i[1];
         ap_write <= hwrite_i;
         ap_addr  <= haddr_i[7:0];
      end
   end

   assign wr_en     = ap_valid && ap_write;
   assign rd_en     = ap_valid && !ap_write;
   assign trigger   = wr_en && (ap_addr == dswdt_pkg::REG_TRIGGER);
   assign cfg_write = wr_en && (ap_addr == dswdt_pkg::REG_CTRL ||
                                ap_addr == dswdt_pkg::REG_STAGE1 ||
                                ap_addr == dswdt_pkg::REG_STAGE2);
   assign expire    = (state == S_ST1 || state == S_ST2) && (cnt == '0);

   // Zero wait state slave, always OKAY
   // No wait states, so the master never stalls
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // Configuration registers
   // A write to ctrl or a stage count also restarts the sequence; a mask write does not
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl   <= dswdt_pkg::CTRL_RST;
         count1 <= CNT_W'(dswdt_pkg::COUNT_RST);
         count2 <= CNT_W'(dswdt_pkg::COUNT_RST);
         mask   <= dswdt_pkg::MASK_RST;
      end else if (wr_en) begin
         case (ap_addr)
            dswdt_pkg::REG_CTRL:   ctrl   <= {23'h000000, hwdata_i[8:0]};
            dswdt_pkg::REG_STAGE1: count1 <= hwdata_i[CNT_W-1:0];
            dswdt_pkg::REG_STAGE2: count2 <= hwdata_i[CNT_W-1:0];
            dswdt_pkg::REG_MASK:   mask   <= hwdata_i[dswdt_pkg::STATUS_W-1:0];
            default:               ;                                      // Others ignored
         endcase
      end
   end

   // Read data loaded at the address phase edge so that it
   // stands through the whole data phase
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
         case (haddr_i[7:0])
            dswdt_pkg::REG_CTRL:   hrdata_o <= ctrl;
            dswdt_pkg::REG_STAGE1: hrdata_o <= 32'(count1);
            dswdt_pkg::REG_STAGE2: hrdata_o <= 32'(count2);
            dswdt_pkg::REG_STATUS: hrdata_o <= {28'h0000000, status};
            dswdt_pkg::REG_MASK:   hrdata_o <= {28'h0000000, mask};
            dswdt_pkg::REG_STATE:  hrdata_o <= {28'h0000000, state};
            default:               hrdata_o <= 32'h0000_0000;  // Unmapped reads zero
         endcase
      end
   end

   // Stage sequencer
   // Each stage loads its count, runs down to zero, then hands on;
   // a stage coded off is passed over without a cycle spent in it
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= S_IDLE;
         cnt   <= '0;
      end else if (!en) begin
         state <= S_IDLE;
         cnt   <= '0;
      end else if (cfg_write) begin
         // New settings take hold one cycle later, from idle
         state <= S_IDLE;
         cnt   <= '0;
      end else if (trigger || state == S_IDLE) begin
         // Service restarts at the first enabled stage
         if (act1.enabled) begin
            state <= S_ST1;
            cnt   <= count1;
         end else if (act2.enabled) begin
            state <= S_ST2;
            cnt   <= count2;
         end else begin
            state <= S_DONE;
         end
      end else begin
         case (state)
            S_ST1: begin
               if (cnt == '0) begin
                  if (act2.enabled) begin
                     state <= S_ST2;
                     cnt   <= count2;
                  end else begin
                     state <= S_DONE;
                  end
               end else begin
                  cnt <= cnt - CNT_W'(1);
               end
            end
            S_ST2: begin
               if (cnt == '0) begin
                  state <= S_DONE;
               end else begin
                  cnt <= cnt - CNT_W'(1);
               end
            end
            S_DONE:  state <= S_DONE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // Expiry events of this cycle
   // A service in the expiry cycle wins, so no action is taken
   always_comb begin
      events = '0;
      if (expire && en && !trigger && !cfg_write) begin
         if (state == S_ST1) begin
            events[dswdt_pkg::ST_EXP1_BIT] = 1'b1;
            events[dswdt_pkg::ST_TOUT_BIT] = act1.do_tout;
            events[dswdt_pkg::ST_RST_BIT]  = act1.do_reset;
         end else begin
            events[dswdt_pkg::ST_EXP2_BIT] = 1'b1;
            events[dswdt_pkg::ST_TOUT_BIT] = act2.do_tout;
            events[dswdt_pkg::ST_RST_BIT]  = act2.do_reset;
         end
      end
   end

   // Timeout pin, sticky until reset
   // Only a reset of the block lowers it again
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         watchdog_timeout_out_o <= 1'b0;
      end else if (events[dswdt_pkg::ST_TOUT_BIT]) begin
         watchdog_timeout_out_o <= 1'b1;
      end
   end

   // Module reset pulse
   // Length counts down; a new expiry restarts it
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_cnt        <= 4'h0;
         module_reset_o <= 1'b0;
      end else if (events[dswdt_pkg::ST_RST_BIT]) begin
         rst_cnt        <= dswdt_pkg::RST_PULSE_CYC;
         module_reset_o <= 1'b1;
      end else if (rst_cnt != 4'h0) begin
         rst_cnt        <= rst_cnt - 4'h1;
         module_reset_o <= (rst_cnt != 4'h1);
      end
   end

   // Sticky status, read clears, set wins
   // An event in the clearing read cycle stays set
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status <= '0;
      end else if (rd_en && ap_addr == dswdt_pkg::REG_STATUS) begin
         status <= events;
      end else begin
         status <= status | events;
      end
   end

   // Interrupt output
   // Registered, so it follows status one cycle late
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & mask);
      end
   end

   // Assertions
   // Pin never falls while out of reset
   tout_sticky_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      watchdog_timeout_out_o |=> watchdog_timeout_out_o)
      else $error("timeout output dropped without reset");
   // Pin rises only from a stage tied to it
   tout_cause_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(watchdog_timeout_out_o) |-> $past(expire) &&
      (($past(state) == S_ST1 && $past(act1.do_tout)) ||
       ($past(state) == S_ST2 && $past(act2.do_tout))))
      else $error("timeout output rose without a timing stage expiry");
   // A stage coded off is never counted
   skip_off_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (state == S_ST1) |-> act1.enabled)
      else $error("disabled first stage was counted");
   skip2_off_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (state == S_ST2) |-> act2.enabled)
      else $error("disabled second stage was counted");
   // Delay code is ignored in stage two
   delay_first_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (ctrl[dswdt_pkg::CTRL_ACT2_LSB +: 4] == dswdt_pkg::ACT_DELAY) |-> !act2.enabled)
      else $error("delay code accepted in second stage");
   // Stage two follows stage one's expiry
   stage_seq_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (state == S_ST1 && cnt == '0 && act2.enabled && en && !trigger && !cfg_write)
      |=> state == S_ST2 && cnt == $past(count2))
      else $error("second stage did not follow the first");
   // Service restarts stage one
   trig_restart_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (trigger && en && act1.enabled) |=> state == S_ST1)
      else $error("trigger did not restart stage one");
   // New settings restart from idle
   cfg_restart_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      cfg_write |=> state == S_IDLE)
      else $error("configuration write did not restart the sequence");
   // Reset request lasts eight cycles
   reset_pulse_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      events[dswdt_pkg::ST_RST_BIT] |=> module_reset_o [*8] ##1 !module_reset_o)
      else $error("module reset pulse length wrong");
   // Stage two reset action raises request
   rst_act2_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (expire && state == S_ST2 && act2.do_reset && en && !trigger && !cfg_write)
      |=> module_reset_o)
      else $error("second stage reset action gave no request");
   // Finished sequence waits for service
   done_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (state == S_DONE && !trigger && !cfg_write && en) |=> state == S_DONE)
      else $error("sequencer left done state unserviced");
   // Missed service in stage one acts
   miss_act_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (expire && !trigger && !cfg_write && en && state == S_ST1 && act1.do_tout)
      |=> watchdog_timeout_out_o)
      else $error("missed service took no action");
   // Untied stage leaves the pin alone
   tie_stage_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (expire && state == S_ST2 && !act2.do_tout && !watchdog_timeout_out_o)
      |=> !watchdog_timeout_out_o)
      else $error("output asserted by stage not tied to it");
   // Sequencer stays one-hot
   state_hot_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      $onehot(state))
      else $error("sequencer state not one-hot");
   // Interrupt follows unmasked status
   irq_level_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      1'b1 |=> irq_o == $past(|(status & mask)))
      else $error("interrupt does not follow unmasked status");
   // Main scenarios reached
   tout_cov_c:  cover property (@(posedge core_clk_i) $rose(watchdog_timeout_out_o));
   rst_cov_c:   cover property (@(posedge core_clk_i) $rose(module_reset_o));
   seq_cov_c:   cover property (@(posedge core_clk_i) state == S_ST1 ##1 state == S_ST2);
   irq_cov_c:   cover property (@(posedge core_clk_i) $rose(irq_o));
   done_cov_c:  cover property (@(posedge core_clk_i) state == S_DONE);
endmodule : dswdt_top

// *** verification/dswdt_baseboard.sv ***
// Baseboard model that watches the timeout pin and the module reset request
`timescale 1ns/1ps
module dswdt_baseboard (
   input  wire logic core_clk_i,   // Module clock
   input  wire logic reset_n_i,    // System reset, active low
   input  wire logic tout_pin_i,   // Timeout pin level
   input  wire logic mod_rst_i,    // Module reset request
   output int        rst_pulses_o, // Reset pulses seen
   output int        rst_len_o,    // Cycles of the last pulse
   output int        pin_drops_o   // Pin releases without a reset
);
   logic pin_q; // Pin level one cycle back
   logic rst_q; // Request level one cycle back
   // Tally reset pulses and catch a pin that lets go on its own
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_q        <= 1'b0;
         rst_q        <= 1'b0;
         rst_pulses_o <= 0;
         rst_len_o    <= 0;
         pin_drops_o  <= 0;
      end else begin
         pin_q <= tout_pin_i;
         rst_q <= mod_rst_i;
         // New pulse starts a fresh length count
         if (mod_rst_i && !rst_q) begin
            rst_pulses_o <= rst_pulses_o + 1;
            rst_len_o    <= 1;
         end else if (mod_rst_i) begin
            rst_len_o <= rst_len_o + 1;
         end
         // Pin may only fall through reset
         if (pin_q && !tout_pin_i) begin
            pin_drops_o <= pin_drops_o + 1;
         end
      end
   end
endmodule : dswdt_baseboard

// *** verification/dual_stage_watchdog_test.sv ***
// Self-checking bench for the dual stage watchdog
`timescale 1ns/1ps
module dual_stage_watchdog_test;
   logic        core_clk_i;             // Bench clock
   logic        reset_n_i;              // Reset, active low
   logic        hsel_i;                 // Bus select
   logic [31:0] haddr_i;                // Bus address
   logic [1:0]  htrans_i;               // Transfer type
   logic        hwrite_i;               // Write flag
   logic [2:0]  hsize_i;                // Transfer size
   logic [31:0] hwdata_i;               // Write data
   logic        hready_i;               // Bus ready, from the slave
   logic [31:0] hrdata_o;               // Read data
   logic        hreadyout_o;            // Slave ready
   logic        hresp_o;                // Slave response
   logic        watchdog_timeout_out_o; // Timeout pin
   logic        module_reset_o;         // Module reset request
   logic        irq_o;                  // Interrupt
   int          rst_pulses;             // Pulses seen by the baseboard
   int          rst_len;                // Length of last pulse
   int          pin_drops;              // Illegal pin releases
   int          miscompares;            // Mismatch count
   int          n_tests;                // Comparison count
   logic [31:0] rd;                     // Last read value
   logic [3:0]  codes [6];              // Every action code
   logic [7:0]  r_adr [6];              // Reset value addresses
   logic [31:0] r_val [6];              // Expected reset values
   assign hready_i = hreadyout_o; // One slave drives the bus ready
   dswdt_top u_dswdt_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
      .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .watchdog_timeout_out_o(watchdog_timeout_out_o), .module_reset_o(module_reset_o),
      .irq_o(irq_o));
   dswdt_baseboard u_dswdt_baseboard (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .tout_pin_i(watchdog_timeout_out_o), .mod_rst_i(module_reset_o),
      .rst_pulses_o(rst_pulses), .rst_len_o(rst_len), .pin_drops_o(pin_drops));
   // Free running 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // Verdict and end of run
   task automatic complete_run();
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   // Compare one value and report a mismatch
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // One single AHB-Lite word transfer, read data kept in rd
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_i   <= 1'b1;
      haddr_i  <= {24'h000000, a};
      hwrite_i <= w;
      htrans_i <= 2'h2;
      @(posedge core_clk_i);
      while (hready_i !== 1'b1) @(posedge core_clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      @(posedge core_clk_i);
      while (hready_i !== 1'b1) @(posedge core_clk_i);
      rd = hrdata_o;
   endtask : xfer
   // Reset held for 16 cycles
   task automatic do_rst();
      reset_n_i <= 1'b0;
      repeat (16) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(posedge core_clk_i);
   endtask : do_rst
   // Reference model: status bits expected once the sequence has run out
   function automatic logic [31:0] model_st(input logic [3:0] a1, input logic [3:0] a2);
      logic [31:0] st;
      bit          e1;
      bit          e2;
      st = 32'h0;
      e1 = a1 inside {4'h1, 4'h5, 4'h8, 4'h9, 4'hd};
      e2 = a2 inside {4'h1, 4'h8, 4'h9};
      st[dswdt_pkg::ST_EXP1_BIT] = e1;
      st[dswdt_pkg::ST_EXP2_BIT] = e2;
      st[dswdt_pkg::ST_TOUT_BIT] = (e1 && a1[3]) || (e2 && a2[3]);
      st[dswdt_pkg::ST_RST_BIT]  = (e1 && a1[0] && !a1[2]) || (e2 && a2[0]);
      return st;
   endfunction : model_st
   // Program both stages, let them run out, compare with the model
   task automatic run_case(input logic [3:0] a1, input logic [3:0] a2);
      int          c1;
      int          c2;
      logic [31:0] st;
      logic        t1;
      c1 = 8 + $urandom % 16;
      c2 = 8 + $urandom % 16;
      st = model_st(a1, a2);
      // Stage one alone drives the pin when its code carries the output
      t1 = a1 inside {dswdt_pkg::ACT_TOUT, dswdt_pkg::ACT_RST_TOUT, dswdt_pkg::ACT_DLY_TOUT};
      do_rst();
      xfer(1'b1, dswdt_pkg::REG_MASK, 32'hf);
      xfer(1'b1, dswdt_pkg::REG_STAGE1, c1);
      xfer(1'b1, dswdt_pkg::REG_STAGE2, c2);
      xfer(1'b1, dswdt_pkg::REG_CTRL, {23'h0, 1'b1, a2, a1});
      repeat ((st[0] ? c1 : c2) - 2) @(posedge core_clk_i);
      chk("early pin", 32'h0, watchdog_timeout_out_o);
      if (st[0] && st[1]) begin
         repeat (6) @(posedge core_clk_i);
         chk("pin in stage two", {31'h0, t1}, watchdog_timeout_out_o);
      end
      repeat (c1 + c2 + 12) @(posedge core_clk_i);
      chk("pin", st[dswdt_pkg::ST_TOUT_BIT], watchdog_timeout_out_o);
      chk("reset pulses", st[dswdt_pkg::ST_RST_BIT], rst_pulses);
      if (st[dswdt_pkg::ST_RST_BIT]) chk("pulse len", dswdt_pkg::RST_PULSE_CYC, rst_len);
      chk("irq", |st, irq_o);
      xfer(1'b0, dswdt_pkg::REG_STATUS, 32'h0);
      chk("status", st, rd);
      xfer(1'b0, dswdt_pkg::REG_STATUS, 32'h0);
      chk("status cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, irq_o);
      xfer(1'b0, dswdt_pkg::REG_STATE, 32'h0);
      if (st[0] || st[1]) chk("state", 32'h8, rd);
   endtask : run_case
   // Main sequence
   initial begin
      reset_n_i = 1'b0;
      hsel_i    = 1'b0;
      haddr_i   = 32'h0;
      htrans_i  = 2'h0;
      hwrite_i  = 1'b0;
      hsize_i   = 3'h2;
      hwdata_i  = 32'h0;
      miscompares = 0;
      n_tests     = 0;
      void'($urandom(32'h211b4453));
      codes = '{dswdt_pkg::ACT_OFF, dswdt_pkg::ACT_RESET, dswdt_pkg::ACT_DELAY,
                dswdt_pkg::ACT_TOUT, dswdt_pkg::ACT_RST_TOUT, dswdt_pkg::ACT_DLY_TOUT};
      r_adr = '{dswdt_pkg::REG_CTRL, dswdt_pkg::REG_STAGE1, dswdt_pkg::REG_STAGE2,
                dswdt_pkg::REG_MASK, dswdt_pkg::REG_STATUS, 8'h1c};
      r_val = '{dswdt_pkg::CTRL_RST, dswdt_pkg::COUNT_RST, dswdt_pkg::COUNT_RST,
                32'(dswdt_pkg::MASK_RST), 32'h0, 32'h0};
      do_rst();
      chk("pin after reset", 32'h0, watchdog_timeout_out_o);
      xfer(1'b1, dswdt_pkg::REG_STATUS, 32'hf);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, r_adr[i], 32'h0);
         chk("reset value", r_val[i], rd);
      end
      for (int j = 0; j < 12; j++) begin
         run_case(j < 6 ? codes[j] : dswdt_pkg::ACT_OFF, j < 6 ? dswdt_pkg::ACT_OFF : codes[j - 6]);
      end
      run_case(dswdt_pkg::ACT_DELAY, dswdt_pkg::ACT_RST_TOUT);
      run_case(dswdt_pkg::ACT_TOUT, dswdt_pkg::ACT_RESET);
      // Regular service keeps the pin quiet, then service stops
      do_rst();
      xfer(1'b1, dswdt_pkg::REG_STAGE1, 32'd30);
      xfer(1'b1, dswdt_pkg::REG_CTRL, {23'h0, 1'b1, dswdt_pkg::ACT_OFF, dswdt_pkg::ACT_TOUT});
      for (int k = 0; k < 5; k++) begin
         repeat (20) @(posedge core_clk_i);
         xfer(1'b1, dswdt_pkg::REG_TRIGGER, $urandom);
      end
      chk("serviced pin", 32'h0, watchdog_timeout_out_o);
      repeat (45) @(posedge core_clk_i);
      chk("missed service pin", 32'h1, watchdog_timeout_out_o);
      chk("masked irq", 32'h0, irq_o);
      xfer(1'b1, dswdt_pkg::REG_MASK, 32'h1 << dswdt_pkg::ST_TOUT_BIT);
      repeat (3) @(posedge core_clk_i);
      chk("unmasked irq", 32'h1, irq_o);
      repeat (30) @(posedge core_clk_i);
      chk("held pin", 32'h1, watchdog_timeout_out_o);
      chk("pin drops", 32'h0, pin_drops);
      do_rst();
      chk("pin cleared", 32'h0, watchdog_timeout_out_o);
      complete_run();
   end
   // Hang guard
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
endmodule : dual_stage_watchdog_test
